// *** hdl/dal_pkg.sv ***
// Purpose: constants for the diagnostic converter result and alarm latch
// Assumes: 32-bit AHB-Lite register words, byte address = index * 4
// Notes: register indexes, slots, codes, field positions and reset values
// Contract
// - slot 1 converts external input a, slot 2 external input b
// - results stored as unsigned 12-bit straight binary, step = span / 4096
// - ideal codes 000 at zero, 800 at mid, FFF at full scale
// - two-bit rate select picks 640, 1280, 2560 or 3840 Hz for external inputs
// - span bit 0 gives twice reference, 1 reference; low aux supply forces reference
// - external input a result at 24h, external input b result at 25h
// - slot 3 converts die temperature at fixed rate, result at 26h
// - five self-diagnostic results reported through register 27h
// - slots 4 to 8 convert diagnostic nodes in order at fixed 2560 Hz
// - dac output monitor uses wide span when aux supply above 2.7 V
// - substitute data at 2Eh read/write; offset enable replaces offset correction
// - result enable skips conversion and stores substitute data in result
// - alarm bit set when monitored result leaves its threshold window
// - alarm bits stay set until read; read clears all; persistent condition resets
// - when an alarm event clears, dac reloads from its active registers
// - unmasked alarm drives interrupt pin; masked alarm only sets status
// - interrupt pin depends only on alarm status and mask
// - offset correction is 7FFh minus offset conversion, subtracted unless bypassed
// - alarm reported after consecutive failures exceed the fail limit by one
`default_nettype none
package dal_pkg;
  // register indexes, byte address is four times the index
  localparam logic [7:0] IDX_EXT_A = 8'h24;
  localparam logic [7:0] IDX_EXT_B = 8'h25;
  localparam logic [7:0] IDX_TEMP = 8'h26;
  localparam logic [7:0] IDX_DIAG = 8'h27;
  localparam logic [7:0] IDX_OFFSET = 8'h28;
  localparam logic [7:0] IDX_SUBST = 8'h2E;
  localparam logic [7:0] IDX_CFG = 8'h30;
  localparam logic [7:0] IDX_THR_A = 8'h31;
  localparam logic [7:0] IDX_THR_B = 8'h32;
  localparam logic [7:0] IDX_THR_T = 8'h33;
  localparam logic [7:0] IDX_STATUS = 8'h34;
  localparam logic [7:0] IDX_MASK = 8'h35;
  // sequencer slots
  localparam logic [3:0] SLOT_OFFSET = 4'h0;
  localparam logic [3:0] SLOT_EXT_A = 4'h1;
  localparam logic [3:0] SLOT_EXT_B = 4'h2;
  localparam logic [3:0] SLOT_TEMP = 4'h3;
  localparam logic [3:0] SLOT_DIAG_FIRST = 4'h4;
  localparam logic [3:0] SLOT_DIAG_LAST = 4'h8;
  // data rates in Hz, rate select codes
  localparam int RATE_FIXED_HZ = 2560;
  localparam logic [1:0] RATE_640 = 2'h0;
  localparam logic [1:0] RATE_1280 = 2'h1;
  localparam logic [1:0] RATE_2560 = 2'h2;
  localparam logic [1:0] RATE_3840 = 2'h3;
  // codes
  localparam logic [11:0] CODE_ZERO = 12'h000;
  localparam logic [11:0] CODE_MID = 12'h800;
  localparam logic [11:0] CODE_FULL = 12'hFFF;
  localparam logic [11:0] OFFSET_REF = 12'h7FF;
  // field positions
  localparam int SUBST_OFS_EN_BIT = 12;
  localparam int SUBST_RES_EN_BIT = 13;
  localparam int CFG_SPAN_BIT = 2;
  localparam int CFG_LIMIT_LSB = 4;
  localparam int ALARM_COUNT = 3;
  // values after reset
  localparam logic [15:0] SUBST_RESET = 16'h0000;
  localparam logic [15:0] CFG_RESET = 16'h0000;
  localparam logic [15:0] THR_RESET = 16'hFF00;
  localparam logic [2:0] MASK_RESET = 3'h0;
endpackage : dal_pkg
`default_nettype wire

// *** hdl/dal_result_latch.sv ***
// Purpose: result registers, offset path, substitution and alarm latch
// Assumes: converter core on clk delivers one result per convDone pulse
// Notes: reads take one wait state, writes none
//   hsize is ignored; each register is one word, data in the low bits
//   an alarm condition ends on the first in-range result, no hysteresis
//   a status set in the read-clear cycle wins over the clear
//   clkEn low freezes every flop, the bus handshake included
//   conversion inputs come from logic on clk and pass no synchroniser
//   the diag register keeps the latest of the five diag slots, slot tag on top
`timescale 1ns/100ps
`default_nettype none
module dal_result_latch #(
  parameter int LIMIT_W = 3
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clkEn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // converter core
  input wire logic convDone,
  input wire logic [3:0] convSlot,
  input wire logic [11:0] convRaw,
  input wire logic auxSupplyHigh,
  output logic [1:0] sampleRateSelect,
  output logic spanWideExt,
  output logic spanWideDac,
  // system
  output logic alarmIrq,
  output logic dacReload
);
  import dal_pkg::*;

  // bus state
  logic dataPhase_reg;
  logic dataWrite_reg;
  logic [7:0] dataIdx_reg;
  // result registers
  logic [15:0] extA_reg;
  logic [15:0] extB_reg;
  logic [15:0] temp_reg;
  logic [15:0] diag_reg;
  logic [11:0] offset_reg;

  // software-written registers
  logic [15:0] subst_reg;
  logic [15:0] cfg_reg;
  logic [15:0] thr_reg [ALARM_COUNT];
  logic [ALARM_COUNT-1:0] mask_reg;

  // alarm state
  logic [ALARM_COUNT-1:0] status_reg;
  logic [ALARM_COUNT-1:0] condition_reg;
  logic [LIMIT_W-1:0] failCnt_reg [ALARM_COUNT];
  // aux supply synchroniser
  logic auxS1_reg;
  logic auxS2_reg;
  logic auxS3_reg;
  logic auxHigh_reg;

  // combinational data path
  logic [11:0] offsetCorr;
  logic [12:0] corrected;
  logic [11:0] resultCode;
  logic statusRead;
  logic readEnd;
  logic statusClear;
  logic [ALARM_COUNT-1:0] outOfRange;
  logic [ALARM_COUNT-1:0] alarmSet;
  logic [ALARM_COUNT-1:0] alarmFall;
  logic [ALARM_COUNT-1:0] hitSlot;
  logic [31:0] readMux;

  // slot to alarm channel decode
  function automatic logic [ALARM_COUNT-1:0] slotHit(input logic [3:0] slot);
    slotHit = {slot == SLOT_TEMP, slot == SLOT_EXT_B, slot == SLOT_EXT_A};
  endfunction : slotHit

  // threshold field expand, low nibble fixed
  function automatic logic [11:0] thrHigh(input logic [15:0] thr);
    thrHigh = {thr[15:8], 4'hF};
  endfunction : thrHigh

  function automatic logic [11:0] thrLow(input logic [15:0] thr);
    thrLow = {thr[7:0], 4'h0};
  endfunction : thrLow

  // result outside the threshold window of one channel
  function automatic logic windowMiss(input logic [11:0] code, input logic [15:0] thr);
    windowMiss = (code > thrHigh(thr)) || (code < thrLow(thr));
  endfunction : windowMiss

  // substitute replaces offset correction when enabled
  assign offsetCorr = subst_reg[SUBST_OFS_EN_BIT] ? subst_reg[11:0] : offset_reg;
  // subtract signed correction, keep straight binary within 000..FFF
  assign corrected = {1'b0, convRaw} - {offsetCorr[11], offsetCorr};
  always_comb begin
    if (subst_reg[SUBST_RES_EN_BIT]) begin
      resultCode = subst_reg[11:0];
    end else if (corrected[12] && offsetCorr[11]) begin
      resultCode = CODE_FULL;
    end else if (corrected[12]) begin
      resultCode = CODE_ZERO;
    end else begin
      resultCode = corrected[11:0];
    end
  end

  // this cycle's conversion channel and bus read events
  assign hitSlot = convDone ? slotHit(convSlot) : '0;
  assign statusRead = dataPhase_reg && !dataWrite_reg && (dataIdx_reg == IDX_STATUS);
  // a read's wait state ends at this edge; status clears then
  assign readEnd = dataPhase_reg && !dataWrite_reg && !hreadyout;
  assign statusClear = statusRead && !hreadyout;

  // window check and failure counting per monitored channel
  genvar gi;
  generate
    for (gi = 0; gi < ALARM_COUNT; gi++) begin : g_alarm
      assign outOfRange[gi] = windowMiss(resultCode, thr_reg[gi]);
      assign alarmSet[gi] = hitSlot[gi] && outOfRange[gi]
        && (failCnt_reg[gi] >= cfg_reg[CFG_LIMIT_LSB +: LIMIT_W]);
      assign alarmFall[gi] = hitSlot[gi] && !outOfRange[gi] && condition_reg[gi];

      // consecutive failure counter, cleared by an in-range result
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          failCnt_reg[gi] <= '0;
        end else if (clkEn && hitSlot[gi]) begin
          if (!outOfRange[gi]) begin
            failCnt_reg[gi] <= '0;
          end else if (failCnt_reg[gi] != {LIMIT_W{1'b1}}) begin
            failCnt_reg[gi] <= failCnt_reg[gi] + 1'b1;
          end
        end
      end

      // live alarm condition, ends on the next in-range result
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          condition_reg[gi] <= 1'b0;
        end else if (clkEn && hitSlot[gi]) begin
          condition_reg[gi] <= alarmSet[gi] || (condition_reg[gi] && outOfRange[gi]);
        end
      end
    end
  endgenerate

  // read data selection
  always_comb begin
    readMux = 32'h0000_0000;
    case (dataIdx_reg)
      IDX_EXT_A: readMux[15:0] = extA_reg;
      IDX_EXT_B: readMux[15:0] = extB_reg;
      IDX_TEMP: readMux[15:0] = temp_reg;
      IDX_DIAG: readMux[15:0] = diag_reg;
      IDX_OFFSET: readMux[11:0] = offset_reg;
      IDX_SUBST: readMux[15:0] = subst_reg;
      IDX_CFG: readMux[15:0] = cfg_reg;
      IDX_THR_A: readMux[15:0] = thr_reg[0];
      IDX_THR_B: readMux[15:0] = thr_reg[1];
      IDX_THR_T: readMux[15:0] = thr_reg[2];
      IDX_STATUS: readMux[ALARM_COUNT-1:0] = status_reg;
      IDX_MASK: readMux[ALARM_COUNT-1:0] = mask_reg;
      default: readMux = 32'h0000_0000;
    endcase
  end

  // bus address phase capture; reads add one wait state
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dataPhase_reg <= 1'b0;
      dataWrite_reg <= 1'b0;
      dataIdx_reg <= 8'h00;
      hreadyout <= 1'b1;
    end else if (clkEn) begin
      if (readEnd) begin
        dataPhase_reg <= 1'b0;
        hreadyout <= 1'b1;
      end else if (hready && hsel && htrans[1]) begin
        dataPhase_reg <= 1'b1;
        dataWrite_reg <= hwrite;
        dataIdx_reg <= haddr[9:2];
        hreadyout <= hwrite;
      end else if (hready) begin
        dataPhase_reg <= 1'b0;
      end
    end
  end

  // read data loaded as the read wait state ends
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hrdata <= 32'h0000_0000;
    end else if (clkEn && readEnd) begin
      hrdata <= readMux;
    end
  end

  // response is always okay
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hresp <= 1'b0;
    end else if (clkEn) begin
      hresp <= 1'b0;
    end
  end

  // software-written registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      subst_reg <= SUBST_RESET;
      cfg_reg <= CFG_RESET;
      thr_reg[0] <= THR_RESET;
      thr_reg[1] <= THR_RESET;
      thr_reg[2] <= THR_RESET;
      mask_reg <= MASK_RESET;
    end else if (clkEn && dataPhase_reg && dataWrite_reg) begin
      case (dataIdx_reg)
        IDX_SUBST: subst_reg <= {2'b00, hwdata[13:0]};
        IDX_CFG: cfg_reg <= {8'h00, 1'b0, hwdata[6:4], 1'b0, hwdata[2:0]};
        IDX_THR_A: thr_reg[0] <= hwdata[15:0];
        IDX_THR_B: thr_reg[1] <= hwdata[15:0];
        IDX_THR_T: thr_reg[2] <= hwdata[15:0];
        IDX_MASK: mask_reg <= hwdata[ALARM_COUNT-1:0];
        default: ;
      endcase
    end
  end

  // result registers written per sequencer slot
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      extA_reg <= 16'h0000;
      extB_reg <= 16'h0000;
      temp_reg <= 16'h0000;
      diag_reg <= 16'h0000;
      offset_reg <= 12'h000;
    end else if (clkEn && convDone) begin
      if (convSlot == SLOT_OFFSET) begin
        offset_reg <= OFFSET_REF - convRaw;
      end else if (convSlot == SLOT_EXT_A) begin
        extA_reg <= {4'h0, resultCode};
      end else if (convSlot == SLOT_EXT_B) begin
        extB_reg <= {4'h0, resultCode};
      end else if (convSlot == SLOT_TEMP) begin
        temp_reg <= {4'h0, resultCode};
      end else if (convSlot >= SLOT_DIAG_FIRST && convSlot <= SLOT_DIAG_LAST) begin
        diag_reg <= {1'b0, convSlot[2:0], resultCode};
      end
    end
  end

  // sticky alarm status, set wins over read clear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      status_reg <= '0;
    end else if (clkEn) begin
      if (statusClear) begin
        status_reg <= alarmSet;
      end else begin
        status_reg <= status_reg | alarmSet;
      end
    end
  end

  // interrupt from status and mask only
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      alarmIrq <= 1'b0;
    end else if (clkEn) begin
      if (statusClear) begin
        alarmIrq <= |(alarmSet & ~mask_reg);
      end else begin
        alarmIrq <= |((status_reg | alarmSet) & ~mask_reg);
      end
    end
  end

  // dac reload pulse when an alarm condition ends
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dacReload <= 1'b0;
    end else if (clkEn) begin
      dacReload <= |alarmFall;
    end
  end

  // aux supply level through three flops, change once last two agree
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      auxS1_reg <= 1'b0;
      auxS2_reg <= 1'b0;
      auxS3_reg <= 1'b0;
      auxHigh_reg <= 1'b0;
    end else if (clkEn) begin
      auxS1_reg <= auxSupplyHigh;
      auxS2_reg <= auxS1_reg;
      auxS3_reg <= auxS2_reg;
      if (auxS2_reg == auxS3_reg) begin
        auxHigh_reg <= auxS3_reg;
      end
    end
  end

  // rate select toward the converter core
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sampleRateSelect <= RATE_640;
    end else if (clkEn) begin
      sampleRateSelect <= cfg_reg[1:0];
    end
  end

  // external input span, reference while the aux supply is low or the span bit is set
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      spanWideExt <= 1'b0;
    end else if (clkEn) begin
      spanWideExt <= auxHigh_reg && !cfg_reg[CFG_SPAN_BIT];
    end
  end

  // dac monitor span follows the aux supply alone
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      spanWideDac <= 1'b0;
    end else if (clkEn) begin
      spanWideDac <= auxHigh_reg;
    end
  end

endmodule : dal_result_latch
`default_nettype wire

// *** verification/dal_result_latch_chk.sv ***
// Purpose: port-level checks for the result and alarm latch
// Assumes: a transfer counts only on an edge with clkEn high
// Notes: bound to the latch from the bench top file
`timescale 1ns/100ps
`default_nettype none
module dal_result_latch_chk #(
  parameter int LIMIT_W = 3
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clkEn,
  // bus
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  // converter and system
  input wire logic convDone,
  input wire logic auxSupplyHigh,
  input wire logic [1:0] sampleRateSelect,
  input wire logic spanWideExt,
  input wire logic spanWideDac,
  input wire logic alarmIrq,
  input wire logic dacReload
);
  logic rdTaken;
  logic wrTaken;
  // transfers accepted at an edge
  assign rdTaken = clkEn && hsel && hready && htrans[1] && !hwrite;
  assign wrTaken = clkEn && hsel && hready && htrans[1] && hwrite;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  // read data phase: one wait, then ready
  sequence rd_take_s;
    rdTaken;
  endsequence
  sequence rd_wait_s;
    !hreadyout ##1 hreadyout;
  endsequence
  rd_wait_a: assert property (rd_take_s |=> rd_wait_s)
    else $error("read wait state wrong");
  wr_nowait_a: assert property (wrTaken |=> hreadyout)
    else $error("write stalled");
  ready_cause_a: assert property (!hreadyout |-> $past(rdTaken))
    else $error("wait state without read");
  resp_okay_a: assert property (hresp == 1'b0)
    else $error("error response seen");
  rate_write_a: assert property ($changed(sampleRateSelect) |-> $past(wrTaken, 3))
    else $error("rate moved without write");
  span_dac_a: assert property ($stable(auxSupplyHigh) [*8] |-> spanWideDac == auxSupplyHigh)
    else $error("dac span not following supply");
  span_ext_a: assert property (spanWideExt |-> spanWideDac)
    else $error("wide span with low supply");
  irq_rise_a: assert property ($rose(alarmIrq) |-> $past(convDone) || $past(wrTaken, 3))
    else $error("interrupt without cause");
  irq_fall_a: assert property ($fell(alarmIrq) |-> !$past(hreadyout) || $past(wrTaken, 3))
    else $error("interrupt dropped without read");
  reload_a: assert property (dacReload |-> $past(convDone) || $past(convDone, 2))
    else $error("reload without conversion");
endmodule : dal_result_latch_chk
`default_nettype wire

// *** verification/dal_conv_model.sv ***
// Purpose: converter core model handing results to the latch
// Assumes: called from the bench just after a rising edge
// Notes: result lines scramble once the pulse is over
`timescale 1ns/100ps
`default_nettype none
module dal_conv_model (
  // clock
  input wire logic clk,
  // result handed to the latch
  output logic convDone,
  output logic [3:0] convSlot,
  output logic [11:0] convRaw
);
  initial begin
    convDone = 1'b0;
    convSlot = 4'hF;
    convRaw = 12'h000;
  end
  // one result pulse per call, slot order kept by the caller
  task automatic convert(input logic [3:0] slot, input logic [11:0] raw);
    convDone <= 1'b1;
    convSlot <= slot;
    convRaw <= raw;
    @(posedge clk);
    convDone <= 1'b0;
    convSlot <= ~slot;
    convRaw <= ~raw;
    repeat (3) @(posedge clk);
  endtask : convert
endmodule : dal_conv_model
`default_nettype wire

// *** verification/dal_result_latch_tb.sv ***
// Purpose: self-checking bench for the result registers and alarm latch
// Assumes: bus hready is the latch's own hreadyout
// Notes: random codes from a fixed lfsr seed
`timescale 1ns/100ps
`default_nettype none
module dal_result_latch_tb;
  import dal_pkg::*;
  logic clk, rst_n, clkEn, hsel, hwrite, hreadyout, hresp, convDone, auxSupplyHigh;
  logic spanWideExt, spanWideDac, alarmIrq, dacReload;
  logic [31:0] haddr, hwdata, hrdata, rdv, lfsr;
  logic [1:0] htrans, sampleRateSelect;
  logic [2:0] hsize;
  logic [3:0] convSlot;
  logic [11:0] convRaw, raw, d;
  int errors, comparisons, offv, reloads;
  dal_result_latch dal_result_latch_inst (.clk(clk), .rst_n(rst_n), .clkEn(clkEn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .convDone(convDone), .convSlot(convSlot), .convRaw(convRaw), .auxSupplyHigh(auxSupplyHigh),
    .sampleRateSelect(sampleRateSelect), .spanWideExt(spanWideExt), .spanWideDac(spanWideDac),
    .alarmIrq(alarmIrq), .dacReload(dacReload));
  dal_conv_model dal_conv_model_inst (.clk(clk), .convDone(convDone), .convSlot(convSlot),
    .convRaw(convRaw));
  // clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // count of dac reload pulses
  always @(posedge clk) begin
    if (dacReload === 1'b1) begin
      reloads <= reloads + 1;
    end
  end
  function automatic logic [31:0] next_rand(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : next_rand
  // expected code after offset removal, clamped
  function automatic logic [11:0] exp_code(input logic [11:0] r, input int ofs);
    int x;
    x = int'(r) - ofs;
    return (x < 0) ? CODE_ZERO : (x > 4095) ? CODE_FULL : 12'(x);
  endfunction : exp_code
  task automatic give_verdict;
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : give_verdict
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // one single transfer, waits bounded
  task automatic bus(input logic w, input logic [7:0] idx, input logic [31:0] wd);
    int n;
    n = 0;
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {22'h0, idx, 2'h0};
    @(posedge clk);
    while (hreadyout !== 1'b1 && n < 50) begin
      @(posedge clk);
      n++;
    end
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge clk);
    while (hreadyout !== 1'b1 && n < 50) begin
      @(posedge clk);
      n++;
    end
    rdv = hrdata;
    if (n >= 50) begin
      errors++;
      give_verdict();
    end
  endtask : bus
  task automatic rd_chk(input logic [7:0] idx, input logic [31:0] exp);
    bus(1'b0, idx, 32'h0);
    check(rdv, exp);
  endtask : rd_chk
  task automatic conv(input int s, input logic [11:0] r);
    dal_conv_model_inst.convert(4'(s), r);
  endtask : conv
  // main sequence
  initial begin
    errors = 0;
    comparisons = 0;
    lfsr = 32'h69B8;
    rst_n = 1'b0;
    clkEn = 1'b1;
    hsel = 1'b0;
    htrans = 2'h0;
    hwrite = 1'b0;
    haddr = 32'h0;
    hwdata = 32'h0;
    hsize = 3'h2;
    auxSupplyHigh = 1'b0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    rd_chk(IDX_SUBST, 32'h0);
    lfsr = next_rand(lfsr);
    bus(1'b1, IDX_SUBST, {20'h0, lfsr[11:0]});
    rd_chk(IDX_SUBST, {20'h0, lfsr[11:0]});
    bus(1'b1, 8'h3F, 32'hFFFF);
    rd_chk(8'h3F, 32'h0);
    bus(1'b1, IDX_SUBST, 32'h0);
    $display("test registers done");
    for (int k = 0; k < 4; k++) begin
      lfsr = next_rand(lfsr);
      conv(0, lfsr[11:0]);
      offv = 2047 - int'(lfsr[11:0]);
      rd_chk(IDX_OFFSET, {20'h0, 12'(offv)});
      for (int s = 1; s < 9; s++) begin
        lfsr = next_rand(lfsr);
        raw = (k == 0) ? CODE_ZERO : (k == 1) ? CODE_FULL : lfsr[11:0];
        conv(s, raw);
        if (s == 1) begin
          bus(1'b1, IDX_EXT_A, 32'h0ABC);
        end
        if (s < 4) begin
          rd_chk(IDX_EXT_A + 8'(s - 1), {20'h0, exp_code(raw, offv)});
        end else begin
          rd_chk(IDX_DIAG, {17'h0, 3'(s), exp_code(raw, offv)});
        end
      end
    end
    $display("test conversions done");
    lfsr = next_rand(lfsr);
    d = lfsr[11:0];
    raw = lfsr[27:16];
    bus(1'b1, IDX_SUBST, {18'h0, 2'h1, d});
    conv(1, raw);
    rd_chk(IDX_EXT_A, {20'h0, exp_code(raw, int'($signed(d)))});
    bus(1'b1, IDX_SUBST, {18'h0, 2'h2, d});
    conv(2, raw);
    rd_chk(IDX_EXT_B, {20'h0, d});
    // clock enable low: a conversion must leave the results untouched
    clkEn <= 1'b0;
    conv(1, ~raw);
    clkEn <= 1'b1;
    rd_chk(IDX_EXT_A, {20'h0, exp_code(raw, int'($signed(d)))});
    conv(8, raw);
    rd_chk(IDX_DIAG, {17'h0, 3'h0, d});
    bus(1'b1, IDX_SUBST, 32'h0);
    $display("test substitute done");
    for (int a = 0; a < 2; a++) begin
      auxSupplyHigh <= 1'(a);
      for (int c = 0; c < 8; c++) begin
        bus(1'b1, IDX_CFG, 32'(c));
        repeat (10) @(posedge clk);
        check(32'(sampleRateSelect), 32'(c % 4));
        check(32'(spanWideExt), 32'(a == 1 && c < 4));
        check(32'(spanWideDac), 32'(a));
      end
    end
    $display("test rate and span done");
    conv(0, OFFSET_REF);
    bus(1'b1, IDX_CFG, 32'h20);
    bus(1'b1, IDX_THR_A, 32'h8040);
    repeat (2) conv(1, 12'h810);
    rd_chk(IDX_STATUS, 32'h0);
    conv(1, 12'h3FF);
    check(32'(alarmIrq), 32'h1);
    rd_chk(IDX_STATUS, 32'h1);
    repeat (3) @(posedge clk);
    check(32'(alarmIrq), 32'h0);
    rd_chk(IDX_STATUS, 32'h0);
    conv(1, 12'h810);
    rd_chk(IDX_STATUS, 32'h1);
    check(32'(reloads), 32'h0);
    conv(1, 12'h80F);
    check(32'(reloads), 32'h1);
    rd_chk(IDX_STATUS, 32'h0);
    bus(1'b1, IDX_MASK, 32'h1);
    repeat (3) conv(1, 12'h3FF);
    check(32'(alarmIrq), 32'h0);
    rd_chk(IDX_STATUS, 32'h1);
    bus(1'b1, IDX_MASK, 32'h0);
    bus(1'b1, IDX_THR_T, 32'h8040);
    repeat (3) conv(3, 12'h3FF);
    check(32'(alarmIrq), 32'h1);
    rd_chk(IDX_STATUS, 32'h4);
    $display("test alarms done");
    give_verdict();
  end
endmodule : dal_result_latch_tb
bind dal_result_latch dal_result_latch_chk #(.LIMIT_W(LIMIT_W)) dal_result_latch_chk_inst (
  .clk(clk), .rst_n(rst_n), .clkEn(clkEn), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
  .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .convDone(convDone),
  .auxSupplyHigh(auxSupplyHigh), .sampleRateSelect(sampleRateSelect),
  .spanWideExt(spanWideExt), .spanWideDac(spanWideDac), .alarmIrq(alarmIrq),
  .dacReload(dacReload));
`default_nettype wire
